// >>> logic/ebcth_defs.vh
`ifndef EBCTH_DEFS_VH
`define EBCTH_DEFS_VH

// Register byte addresses on the internal CPU bus
`define EBCTH_ADDR_CMP0_U0  16'hFF18
`define EBCTH_ADDR_CMP1_U0  16'hFF19
`define EBCTH_ADDR_CMP0_U1  16'hFF1A
`define EBCTH_ADDR_CMP1_U1  16'hFF1B
`define EBCTH_ADDR_MODE_U0  16'hFF69
`define EBCTH_ADDR_MODE_U1  16'hFF6C

// Reset values
`define EBCTH_RST_BYTE      8'h00
`define EBCTH_RST_CNT       8'h00
`define EBCTH_READ_ZERO     8'h00

// Mode register fields
`define EBCTH_BIT_EN        7
`define EBCTH_CKS_HI        6
`define EBCTH_CKS_LO        4
`define EBCTH_MD_HI         3
`define EBCTH_MD_LO         2
`define EBCTH_BIT_LEV       1
`define EBCTH_BIT_OE        0

// Operating modes
`define EBCTH_MD_INTERVAL   2'h0
`define EBCTH_MD_CARRIER    2'h1
`define EBCTH_MD_PWM        2'h2

// Clock select codes
`define EBCTH_CKS_C0        3'h0
`define EBCTH_CKS_C1        3'h1
`define EBCTH_CKS_C2        3'h2
`define EBCTH_CKS_C3        3'h3
`define EBCTH_CKS_C4        3'h4
`define EBCTH_CKS_EXT       3'h5

// Divider exponents of the high speed system clock, per unit
`define EBCTH_U0_EXP1       1
`define EBCTH_U0_EXP2       2
`define EBCTH_U0_EXP3       6
`define EBCTH_U0_EXP4       10
`define EBCTH_U1_EXP1       2
`define EBCTH_U1_EXP2       4
`define EBCTH_U1_EXP3       6
`define EBCTH_U1_EXP4       12

// Prescaler and internal oscillator divider widths
`define EBCTH_PRE_W         12
`define EBCTH_OSC_DIV_W     7
`define EBCTH_OSC_DIV_LAST  7'h7F
`define EBCTH_PRE_ONE       12'h001
`define EBCTH_OSC_ONE       7'h01

`endif

// >>> logic/ebcth_clksel.v
`timescale 1ns/10ps
`include "ebcth_defs.vh"

// Count clock enable for one unit: one-cycle ticks from prescaler taps or an external tick
module ebcth_clksel #(
	parameter P_UNIT = 0
) (
	input  wire [`EBCTH_PRE_W-1:0] i_pre,
	input  wire [2:0]              i_sel,
	input  wire                    i_ext_tick,
	output reg                     o_tick
);

	function tap;
		input [`EBCTH_PRE_W-1:0] pre;
		input integer            e;
		reg   [`EBCTH_PRE_W-1:0] mask;
		begin
			mask = (`EBCTH_PRE_ONE << e) - `EBCTH_PRE_ONE;
			tap  = ((pre & mask) == mask);
		end
	endfunction

	always @* begin
		o_tick = 1'b0;
		if (i_sel == `EBCTH_CKS_C0) begin
			o_tick = 1'b1;
		end else if (i_sel == `EBCTH_CKS_C1) begin
			o_tick = tap(i_pre, (P_UNIT == 0) ? `EBCTH_U0_EXP1 : `EBCTH_U1_EXP1);
		end else if (i_sel == `EBCTH_CKS_C2) begin
			o_tick = tap(i_pre, (P_UNIT == 0) ? `EBCTH_U0_EXP2 : `EBCTH_U1_EXP2);
		end else if (i_sel == `EBCTH_CKS_C3) begin
			o_tick = tap(i_pre, (P_UNIT == 0) ? `EBCTH_U0_EXP3 : `EBCTH_U1_EXP3);
		end else if (i_sel == `EBCTH_CKS_C4) begin
			o_tick = tap(i_pre, (P_UNIT == 0) ? `EBCTH_U0_EXP4 : `EBCTH_U1_EXP4);
		end else if (i_sel == `EBCTH_CKS_EXT) begin
			o_tick = i_ext_tick;
		end
	end

endmodule

// >>> logic/ebcth_timer.v
// How it works
// - Primary compare: 8-bit byte register, reset zero.
// - Secondary compare buffered; transfers on secondary match.
// - Write colliding with transfer cancels that transfer.
// - Carrier mode: secondary match interrupts, clears counter.
// - Enable low stops and zeroes counter; high counts.
// - Clock select picks prescaler tap, companion (first unit) or oscillator (second unit).
// - Mode field selects interval, PWM or carrier (carrier on second unit only).
// - Level bit sets default except in carrier; output enable bit gates output.
// - Mode register byte writable, bits 7, 1 and 0 also bit writable, reset zero.
// - Second unit uses companion interrupt for carrier.
// - Interval: primary match interrupts and clears counter.
// - Interval: secondary compare matches are ignored.
`timescale 1ns/10ps
`include "ebcth_defs.vh"

module ebcth_timer (
	input  wire        i_core_clk,
	input  wire        i_rstn,
	input  wire [15:0] i_addr,
	input  wire [7:0]  i_wdata,
	input  wire        i_wr,
	input  wire        i_bit_wr,
	input  wire [2:0]  i_bit_sel,
	input  wire        i_bit_val,
	input  wire        i_rd,
	output reg  [7:0]  o_rdata,
	input  wire        i_companion_timer_output,
	input  wire        i_companion_timer_interrupt,
	input  wire        i_internal_osc_clock,
	output wire [1:0]  o_timer_output_pin,
	output wire [1:0]  o_timer_match_interrupt
);

	// Free running prescaler on the high speed system clock
	reg  [`EBCTH_PRE_W-1:0] pre_q;

	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			pre_q <= {`EBCTH_PRE_W{1'b0}};
		end else begin
			pre_q <= pre_q + `EBCTH_PRE_ONE;
		end
	end

	// Companion output and oscillator pin inputs pass two flip-flops before use; the companion interrupt is used directly
	reg  [1:0] cto_sync_q;
	reg  [1:0] osc_sync_q;
	reg        cto_prev_q;
	reg        osc_prev_q;
	reg  [`EBCTH_OSC_DIV_W-1:0] osc_div_q;

	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			cto_sync_q <= 2'h0;
			osc_sync_q <= 2'h0;
			cto_prev_q <= 1'b0;
			osc_prev_q <= 1'b0;
			osc_div_q  <= {`EBCTH_OSC_DIV_W{1'b0}};
		end else begin
			cto_sync_q <= {cto_sync_q[0], i_companion_timer_output};
			osc_sync_q <= {osc_sync_q[0], i_internal_osc_clock};
			cto_prev_q <= cto_sync_q[1];
			osc_prev_q <= osc_sync_q[1];
			if (osc_sync_q[1] && !osc_prev_q) begin
				osc_div_q <= osc_div_q + `EBCTH_OSC_ONE;
			end
		end
	end

	wire cto_tick = cto_sync_q[1] && !cto_prev_q;
	// Internal oscillator divided by 128 for the second unit
	wire osc_tick = osc_sync_q[1] && !osc_prev_q && (osc_div_q == `EBCTH_OSC_DIV_LAST);

	// Flat views of per-unit registers for the read mux
	wire [15:0] cmp0_v;
	wire [15:0] cmp1_v;
	wire [15:0] mode_v;

	genvar u;
	generate
		for (u = 0; u < 2; u = u + 1) begin : g_unit
			localparam [15:0] A_CMP0 = (u == 0) ? `EBCTH_ADDR_CMP0_U0 : `EBCTH_ADDR_CMP0_U1;
			localparam [15:0] A_CMP1 = (u == 0) ? `EBCTH_ADDR_CMP1_U0 : `EBCTH_ADDR_CMP1_U1;
			localparam [15:0] A_MODE = (u == 0) ? `EBCTH_ADDR_MODE_U0 : `EBCTH_ADDR_MODE_U1;

			reg  [7:0] cmp0_q;
			reg  [7:0] cmp1_q;
			reg  [7:0] act1_q;
			reg  [7:0] mode_q;
			reg  [7:0] cnt_q;
			reg        ff_q;
			reg        gate_q;
			reg        pin_q;
			reg        irq_q;

			wire       wr_cmp0 = i_wr && (i_addr == A_CMP0);
			wire       wr_cmp1 = i_wr && (i_addr == A_CMP1);
			wire       wr_mode = i_wr && (i_addr == A_MODE);
			wire       bit_mode = i_bit_wr && (i_addr == A_MODE) &&
				((i_bit_sel == `EBCTH_BIT_EN) || (i_bit_sel == `EBCTH_BIT_LEV) ||
				 (i_bit_sel == `EBCTH_BIT_OE));

			wire       en   = mode_q[`EBCTH_BIT_EN];
			wire [2:0] cks  = mode_q[`EBCTH_CKS_HI:`EBCTH_CKS_LO];
			wire [1:0] md   = mode_q[`EBCTH_MD_HI:`EBCTH_MD_LO];
			wire       lev  = mode_q[`EBCTH_BIT_LEV];
			wire       oe   = mode_q[`EBCTH_BIT_OE];
			// Internal mode control signals
			wire       pwm_mode = (md == `EBCTH_MD_PWM);
			wire       car_mode = (u == 1) && (md == `EBCTH_MD_CARRIER);
			wire       tick;

			ebcth_clksel #(
				.P_UNIT (u)
			) u_clksel (
				.i_pre      (pre_q),
				.i_sel      (cks),
				.i_ext_tick ((u == 0) ? cto_tick : osc_tick),
				.o_tick     (tick)
			);

			wire       step = en && tick;
			// Carrier mode: low phase ends on primary, high phase on secondary match
			wire       hit0 = step && (cnt_q == cmp0_q) && !(car_mode && ff_q);
			// Secondary match only exists in PWM and carrier modes
			wire       hit1 = step && (cnt_q == act1_q) &&
				(pwm_mode || (car_mode && ff_q));
			wire       clr  = hit0 || (car_mode && hit1);

			// Mode register: byte write or single-bit write
			always @(posedge i_core_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					mode_q <= `EBCTH_RST_BYTE;
				end else if (wr_mode) begin
					mode_q <= i_wdata;
				end else if (bit_mode) begin
					mode_q[i_bit_sel] <= i_bit_val;
				end
			end

			// Compare registers
			always @(posedge i_core_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					cmp0_q <= `EBCTH_RST_BYTE;
					cmp1_q <= `EBCTH_RST_BYTE;
					act1_q <= `EBCTH_RST_BYTE;
				end else begin
					if (wr_cmp0) begin
						cmp0_q <= i_wdata;
					end
					if (wr_cmp1) begin
						cmp1_q <= i_wdata;
					end
					// Stopped: a write loads the active value at once
					if (!en && wr_cmp1) begin
						act1_q <= i_wdata;
					end else if (hit1 && !wr_cmp1) begin
						act1_q <= cmp1_q;
					end
				end
			end

			// Counter
			always @(posedge i_core_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					cnt_q <= `EBCTH_RST_CNT;
				end else if (!en) begin
					cnt_q <= `EBCTH_RST_CNT;
				end else if (clr) begin
					cnt_q <= `EBCTH_RST_CNT;
				end else if (step) begin
					cnt_q <= cnt_q + 8'h01;
				end
			end

			// Output flip-flop and match interrupt
			always @(posedge i_core_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					ff_q  <= 1'b0;
					irq_q <= 1'b0;
				end else begin
					irq_q <= car_mode ? hit1 : hit0;
					if (!en) begin
						ff_q <= car_mode ? 1'b0 : lev;
					end else if (car_mode) begin
						if (hit0) begin
							ff_q <= 1'b1;
						end else if (hit1) begin
							ff_q <= 1'b0;
						end
					end else if (pwm_mode) begin
						if (hit0) begin
							ff_q <= ~lev;
						end else if (hit1) begin
							ff_q <= lev;
						end
					end else if (hit0) begin
						ff_q <= ~ff_q;
					end
				end
			end

			// Carrier burst gate alternates on each companion timer interrupt
			always @(posedge i_core_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					gate_q <= 1'b0;
				end else if (!en || !car_mode) begin
					gate_q <= 1'b0;
				end else if (i_companion_timer_interrupt) begin
					gate_q <= ~gate_q;
				end
			end

			// Registered pin, low while output is disabled
			always @(posedge i_core_clk or negedge i_rstn) begin
				if (!i_rstn) begin
					pin_q <= 1'b0;
				end else if (!oe) begin
					pin_q <= 1'b0;
				end else if (car_mode) begin
					pin_q <= ff_q && gate_q;
				end else begin
					pin_q <= ff_q;
				end
			end

			assign o_timer_output_pin[u]      = pin_q;
			assign o_timer_match_interrupt[u] = irq_q;
			assign cmp0_v[u*8 +: 8]           = cmp0_q;
			assign cmp1_v[u*8 +: 8]           = cmp1_q;
			assign mode_v[u*8 +: 8]           = mode_q;
		end
	endgenerate

	// Read data, one cycle after the read strobe; unmapped reads zero
	reg [7:0] rdata_d;

	always @* begin
		rdata_d = `EBCTH_READ_ZERO;
		if (i_addr == `EBCTH_ADDR_CMP0_U0) begin
			rdata_d = cmp0_v[7:0];
		end else if (i_addr == `EBCTH_ADDR_CMP1_U0) begin
			rdata_d = cmp1_v[7:0];
		end else if (i_addr == `EBCTH_ADDR_CMP0_U1) begin
			rdata_d = cmp0_v[15:8];
		end else if (i_addr == `EBCTH_ADDR_CMP1_U1) begin
			rdata_d = cmp1_v[15:8];
		end else if (i_addr == `EBCTH_ADDR_MODE_U0) begin
			rdata_d = mode_v[7:0];
		end else if (i_addr == `EBCTH_ADDR_MODE_U1) begin
			rdata_d = mode_v[15:8];
		end
	end

	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			o_rdata <= `EBCTH_READ_ZERO;
		end else if (i_rd) begin
			o_rdata <= rdata_d;
		end
	end

endmodule

// >>> verif/ebcth_assertions.sv
`timescale 1ns/10ps
module ebcth_assertions (
	input wire        i_core_clk,
	input wire        i_rstn,
	input wire [15:0] i_addr,
	input wire [7:0]  i_wdata,
	input wire        i_wr,
	input wire        i_bit_wr,
	input wire [2:0]  i_bit_sel,
	input wire        i_bit_val,
	input wire        i_rd,
	input wire [7:0]  o_rdata,
	input wire [1:0]  o_timer_output_pin,
	input wire [1:0]  o_timer_match_interrupt
);
	reg  [7:0] prim_q, mode_q, gap_q;
	reg        run_q;
	wire       irq = o_timer_match_interrupt[0];
	wire       pin = o_timer_output_pin[0];
	default clocking cb @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);
	// Shadow of unit0 registers; gap is only trusted after a full period since enable
	always @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			prim_q <= 8'h00;
			mode_q <= 8'h00;
			gap_q  <= 8'h00;
			run_q  <= 1'b0;
		end else begin
			if (i_wr && i_addr == 16'hFF18)
				prim_q <= i_wdata;
			if (i_wr && i_addr == 16'hFF69)
				mode_q <= i_wdata;
			else if (i_bit_wr && i_addr == 16'hFF69 && (i_bit_sel > 3'h6 || i_bit_sel < 3'h2))
				mode_q[i_bit_sel] <= i_bit_val;
			gap_q <= irq ? 8'h00 : gap_q + 8'h01;
			run_q <= mode_q[7] && (run_q || irq);
		end
	end
	property p_rd_prim; i_rd && i_addr == 16'hFF18 |=> o_rdata == prim_q; endproperty
	a_rd_prim: assert property (p_rd_prim) else $error("primary read wrong");
	property p_rd_mode; i_rd && i_addr == 16'hFF69 |=> o_rdata == mode_q; endproperty
	a_rd_mode: assert property (p_rd_mode) else $error("mode read wrong");
	property p_hold; !i_rd |=> $stable(o_rdata); endproperty
	a_hold: assert property (p_hold) else $error("read data moved");
	property p_oe_off; !mode_q[0] |=> !pin; endproperty
	a_oe_off: assert property (p_oe_off) else $error("output not blocked");
	property p_lvl; ($stable(mode_q) && !mode_q[7] && mode_q[0])[*3] |-> pin == mode_q[1]; endproperty
	a_lvl: assert property (p_lvl) else $error("default level wrong");
	property p_stop_irq; (!mode_q[7])[*2] |-> !irq; endproperty
	a_stop_irq: assert property (p_stop_irq) else $error("interrupt while stopped");
	property p_period; irq && run_q && mode_q[7:2] == 6'h20 |-> gap_q == prim_q; endproperty
	a_period: assert property (p_period) else $error("interval period wrong");
	property p_toggle; irq && mode_q[7] && mode_q[3:2] == 2'h0 && mode_q[0] |=> pin != $past(pin); endproperty
	a_toggle: assert property (p_toggle) else $error("output did not toggle");
endmodule

bind ebcth_timer ebcth_assertions u_chk (
	.i_core_clk(i_core_clk), .i_rstn(i_rstn), .i_addr(i_addr), .i_wdata(i_wdata), .i_wr(i_wr),
	.i_bit_wr(i_bit_wr), .i_bit_sel(i_bit_sel), .i_bit_val(i_bit_val), .i_rd(i_rd), .o_rdata(o_rdata),
	.o_timer_output_pin(o_timer_output_pin), .o_timer_match_interrupt(o_timer_match_interrupt)
);

// >>> verif/tb.sv
`timescale 1ns/10ps
module tb;
	logic        clk, rst_n, wr_en, bit_wr, bit_val, rd_en, rd_pend;
	logic [15:0] addr, ma, pa;
	logic [7:0]  wdata, n;
	logic [2:0]  bit_sel;
	logic [2:0]  cdiv = 3'h0;
	logic        cti = 1'b0;
	logic        osc = 1'b0;
	logic [31:0] seed;
	wire  [7:0]  rdata;
	wire  [1:0]  pin, irq;
	logic [7:0]  exp_q[$];
	int          bad_count, n_compared, per, hits;
	logic [15:0] ra[7] = '{16'hFF18, 16'hFF19, 16'hFF1A, 16'hFF1B, 16'hFF69, 16'hFF6C, 16'hFF00};
	int          tu[10] = '{0, 0, 0, 0, 0, 0, 1, 1, 1, 1};
	int          tc[10] = '{0, 1, 2, 3, 4, 5, 0, 1, 2, 5};
	int          td[10] = '{1, 2, 4, 64, 1024, 8, 1, 4, 16, 256};
	ebcth_timer dut (
		.i_core_clk(clk), .i_rstn(rst_n), .i_addr(addr), .i_wdata(wdata), .i_wr(wr_en), .i_bit_wr(bit_wr),
		.i_bit_sel(bit_sel), .i_bit_val(bit_val), .i_rd(rd_en), .o_rdata(rdata),
		.i_companion_timer_output(cdiv[2]), .i_companion_timer_interrupt(cti), .i_internal_osc_clock(osc),
		.o_timer_output_pin(pin), .o_timer_match_interrupt(irq)
	);
	task automatic test_done();
		$display("compared %0d mismatched %0d", n_compared, bad_count);
		if (bad_count == 0 && n_compared > 0)
			$display("Run complete: PASS");
		else
			$display("Run complete: FAIL");
		$finish;
	endtask
	task automatic chk(input string what, input logic [15:0] e, input logic [15:0] s);
		n_compared++;
		if (s !== e) begin
			bad_count++;
			$display("CHECK FAILED %s expected %h seen %h", what, e, s);
		end
	endtask
	function automatic logic [31:0] xs();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	// Kind 0 byte write, 1 bit write (sel d[2:0], value d[3]), 2 read expecting d
	task automatic bus(input int k, input logic [15:0] a, input logic [7:0] d);
		@(negedge clk);
		addr = a;
		wdata = d;
		bit_sel = d[2:0];
		bit_val = d[3];
		wr_en = (k == 0);
		bit_wr = (k == 1);
		rd_en = (k == 2);
		if (k == 2)
			exp_q.push_back(d);
		@(negedge clk);
		{wr_en, bit_wr, rd_en} = 3'h0;
	endtask
	task automatic wait_irq(input int u);
		per = 0;
		do begin
			@(negedge clk);
			per++;
		end while (irq[u] !== 1'b1 && per < 9000);
		if (per >= 9000) begin
			bad_count++;
			test_done();
		end
	endtask
	// Counts output high cycles over one period that starts at a match interrupt
	task automatic high_cnt(input int u, input int len);
		wait_irq(u);
		hits = 0;
		repeat (len) begin
			@(negedge clk);
			hits += pin[u];
		end
	endtask
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	// Companion output: one rising edge every 8 cycles
	always @(negedge clk) cdiv <= cdiv + 3'h1;
	// Internal oscillator pin: one rising edge every 2 cycles
	always @(negedge clk) osc <= ~osc;
	always @(posedge clk) rd_pend <= rd_en;
	always @(negedge clk) if (rd_pend) chk("rdata", exp_q.pop_front(), rdata);
	initial begin
		{rst_n, wr_en, bit_wr, bit_val, rd_en} = 5'h00;
		{addr, wdata, bit_sel} = 27'h0;
		seed = 32'd25513;
		repeat (16) @(negedge clk);
		rst_n = 1'b1;
		foreach (ra[i]) bus(2, ra[i], 8'h00);
		bus(0, 16'hFF00, 8'hA5);
		bus(2, 16'hFF00, 8'h00);
		for (int i = 0; i < 6; i++) begin
			n = 8'(xs()) & 8'h7F;
			bus(0, ra[i], n);
			bus(2, ra[i], n);
		end
		$display("register test done");
		bus(0, 16'hFF69, 8'h00);
		bus(1, 16'hFF69, 8'h09);
		bus(1, 16'hFF69, 8'h08);
		bus(1, 16'hFF69, 8'h0B);
		bus(2, 16'hFF69, 8'h03);
		chk("pin level", 1, pin[0]);
		bus(1, 16'hFF69, 8'h00);
		repeat (2) @(negedge clk);
		chk("pin blocked", 0, pin[0]);
		$display("bit write test done");
		bus(0, 16'hFF19, 8'h01);
		bus(0, 16'hFF1B, 8'h01);
		foreach (tc[i]) begin
			ma = tu[i] ? 16'hFF6C : 16'hFF69;
			pa = tu[i] ? 16'hFF1A : 16'hFF18;
			n = 8'(1 + xs() % 6);
			bus(0, ma, 8'h00);
			bus(0, pa, n);
			bus(0, ma, {1'b0, 3'(tc[i]), 4'h1});
			bus(1, ma, 8'h0F);
			wait_irq(tu[i]);
			wait_irq(tu[i]);
			chk("period", (n + 1) * td[i], per);
		end
		$display("interval test done");
		// PWM on unit0: period 10, active until secondary match
		bus(0, 16'hFF69, 8'h00);
		bus(0, 16'hFF18, 8'h09);
		bus(0, 16'hFF69, 8'h09);
		bus(0, 16'hFF19, 8'h03);
		bus(1, 16'hFF69, 8'h0F);
		wait_irq(0);
		wait_irq(0);
		chk("pwm period", 10, per);
		high_cnt(0, 10);
		chk("pwm duty", 4, hits);
		// Second write lands on the transfer edge and must cancel it
		bus(0, 16'hFF19, 8'h05);
		bus(0, 16'hFF19, 8'h07);
		high_cnt(0, 10);
		chk("pwm held", 4, hits);
		high_cnt(0, 10);
		chk("pwm reload", 8, hits);
		$display("pwm test done");
		// Carrier on unit1: low 5, high 3, gated by companion interrupt
		bus(0, 16'hFF6C, 8'h00);
		bus(0, 16'hFF1A, 8'h04);
		bus(0, 16'hFF6C, 8'h05);
		bus(0, 16'hFF1B, 8'h02);
		bus(1, 16'hFF6C, 8'h0F);
		wait_irq(1);
		wait_irq(1);
		chk("carrier period", 8, per);
		high_cnt(1, 8);
		chk("carrier gated", 0, hits);
		@(negedge clk) cti = 1'b1;
		@(negedge clk) cti = 1'b0;
		high_cnt(1, 8);
		chk("carrier burst", 3, hits);
		$display("carrier test done");
		bus(0, 16'hFF6C, 8'h00);
		hits = 0;
		repeat (40) begin
			@(negedge clk);
			hits += irq[1];
		end
		chk("stopped irq", 0, hits);
		chk("stopped pin", 0, pin[1]);
		$display("stop test done");
		test_done();
	end
endmodule
